// >>> smc_pkg.sv
// constants for the sleep mode controller
package smc_pkg;
	// register select codes on the configuration port
	localparam logic [2:0] SEL_MODE = 3'h0;
	localparam logic [2:0] SEL_OPTS = 3'h1;
	localparam logic [2:0] SEL_IDLE = 3'h2;
	localparam logic [2:0] SEL_CYCLE = 3'h3;
	localparam logic [2:0] SEL_UNJOINED = 3'h4;
	// reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] OPTS_RST = 8'h00;
	localparam logic [15:0] IDLE_RST = 16'h1388;
	localparam logic [15:0] CYCLE_RST = 16'h0000;
	localparam logic [15:0] UNJOINED_RST = 16'h03e8;
	// legal limits
	localparam logic [15:0] IDLE_MIN = 16'h0001;
	localparam logic [15:0] PERIOD_MAX = 16'h68b0;
	localparam logic [15:0] UNJOINED_MIN = 16'h0001;
	localparam logic [7:0] OPTS_MAX = 8'h04;
	// mode codes
	localparam logic [7:0] MODE_NONE = 8'h00;
	localparam logic [7:0] MODE_HIBERNATE = 8'h01;
	localparam logic [7:0] MODE_DOZE = 8'h02;
	localparam logic [7:0] MODE_CYCLIC = 8'h04;
	localparam logic [7:0] MODE_CYCLIC_PIN = 8'h05;
	// option bits
	localparam int OPT_NO_POLL = 0;
	localparam int OPT_NO_SAMPLE = 1;
	// tick timing
	localparam int CLOCK_HZ = 20000000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;
	localparam int COARSE_PER_FINE = 10;
	typedef enum logic [3:0] {
		ST_AWAKE = 4'h1,
		ST_WAKEUP = 4'h2,
		ST_SLEEP = 4'h4,
		ST_UNJOINED = 4'h8
	} smc_state_t;
endpackage : smc_pkg

// >>> smc_sleep_ctrl.sv
// sleep mode controller: configuration, idle timer, cyclic sleep sequencing
`timescale 1ns/1ns
// Functional notes
// R1 - mode accepts 0,1,2,4,5; 3 and others refused; reset 0
// R2 - option bit 0 clear: poll coordinator on each cyclic wake
// R3 - option bit 1 clear with sampling enabled: one sample on wake
// R4 - sleep after idle time in 1 ms units; range 1..0xffff; reset 0x1388
// R5 - idle timer acts only in cyclic modes 4 and 5
// R6 - host keeps guard time below idle time
// R7 - host programs equal idle time on coordinator and end devices
// R8 - cyclic sleep lasts period in 10 ms units; 0..0x68b0; reset 0
// R9 - host should program equal cyclic period network-wide
// R10 - zero period means direct messages, nothing held
// R11 - held message discarded after 2.5 times the period
// R12 - unjoined device sleeps unjoined period before retry; reset 0x3e8
// R13 - any serial or radio byte restarts the idle timer
// R14 - after sleep: wake, poll and sample, then idle timer again
module smc_sleep_ctrl (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// configuration port
	input wire logic cfgWrite,
	input wire logic [2:0] cfgSel,
	input wire logic [15:0] cfgData,
	output logic [15:0] cfgReadData,
	output logic cfgRefused,
	// activity and status from the module
	input wire logic dataActivity,
	input wire logic isCoordinator,
	input wire logic assocWanted,
	input wire logic assocFailed,
	input wire logic samplingEnabled,
	input wire logic heldMsgPending,
	// control outputs
	output logic sleeping,
	output logic pollRequest,
	output logic sampleRequest,
	output logic holdIndirect,
	output logic discardHeld
);
	logic rstMeta, rstSync;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	function automatic logic isCyclic(input logic [7:0] m);
		isCyclic = (m == smc_pkg::MODE_CYCLIC) || (m == smc_pkg::MODE_CYCLIC_PIN);
	endfunction : isCyclic

	// configuration registers
	logic [7:0] mode_r, mode_nxt, opts_r, opts_nxt;
	logic [15:0] idle_r, idle_nxt, cycle_r, cycle_nxt, unj_r, unj_nxt;
	logic [15:0] rd_r, rd_nxt;
	logic ref_r, ref_nxt;
	always_comb begin
		mode_nxt = mode_r;
		opts_nxt = opts_r;
		idle_nxt = idle_r;
		cycle_nxt = cycle_r;
		unj_nxt = unj_r;
		ref_nxt = 1'b0;
		if (cfgWrite) begin
			case (cfgSel)
				smc_pkg::SEL_MODE: begin
					if (cfgData[15:8] == 8'h00 && (cfgData[7:0] == smc_pkg::MODE_NONE
						|| cfgData[7:0] == smc_pkg::MODE_HIBERNATE || cfgData[7:0] == smc_pkg::MODE_DOZE
						|| isCyclic(cfgData[7:0])))
						mode_nxt = cfgData[7:0]; // R1
					else
						ref_nxt = 1'b1; // R1
				end
				smc_pkg::SEL_OPTS: begin
					if (cfgData <= {8'h00, smc_pkg::OPTS_MAX})
						opts_nxt = cfgData[7:0];
					else
						ref_nxt = 1'b1;
				end
				smc_pkg::SEL_IDLE: begin
					if (cfgData >= smc_pkg::IDLE_MIN)
						idle_nxt = cfgData; // R4
					else
						ref_nxt = 1'b1; // R4
				end
				smc_pkg::SEL_CYCLE: begin
					if (cfgData <= smc_pkg::PERIOD_MAX)
						cycle_nxt = cfgData; // R8
					else
						ref_nxt = 1'b1; // R8
				end
				smc_pkg::SEL_UNJOINED: begin
					if (cfgData >= smc_pkg::UNJOINED_MIN && cfgData <= smc_pkg::PERIOD_MAX)
						unj_nxt = cfgData; // R12
					else
						ref_nxt = 1'b1; // R12
				end
				default: ref_nxt = 1'b1;
			endcase
		end
		case (cfgSel)
			smc_pkg::SEL_MODE: rd_nxt = {8'h00, mode_r};
			smc_pkg::SEL_OPTS: rd_nxt = {8'h00, opts_r};
			smc_pkg::SEL_IDLE: rd_nxt = idle_r;
			smc_pkg::SEL_CYCLE: rd_nxt = cycle_r;
			smc_pkg::SEL_UNJOINED: rd_nxt = unj_r;
			default: rd_nxt = 16'h0000;
		endcase
	end
	always_ff @(posedge clock or negedge rstSync) begin
		if (!rstSync) begin
			mode_r <= smc_pkg::MODE_RST;
			opts_r <= smc_pkg::OPTS_RST;
			idle_r <= smc_pkg::IDLE_RST;
			cycle_r <= smc_pkg::CYCLE_RST;
			unj_r <= smc_pkg::UNJOINED_RST;
			rd_r <= 16'h0000;
			ref_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			opts_r <= opts_nxt;
			idle_r <= idle_nxt;
			cycle_r <= cycle_nxt;
			unj_r <= unj_nxt;
			rd_r <= rd_nxt;
			ref_r <= ref_nxt;
		end
	end
	assign cfgReadData = rd_r;
	assign cfgRefused = ref_r;

	// 1 ms and 10 ms tick dividers
	logic [14:0] div_r, div_nxt;
	logic [3:0] dec_r, dec_nxt;
	logic msTick, tenTick;
	always_comb begin
		msTick = (div_r == 15'(smc_pkg::TICK_CYCLES - 1));
		tenTick = msTick && (dec_r == 4'(smc_pkg::COARSE_PER_FINE - 1));
		div_nxt = msTick ? 15'h0000 : div_r + 15'h0001;
		dec_nxt = dec_r;
		if (msTick)
			dec_nxt = tenTick ? 4'h0 : dec_r + 4'h1;
	end
	always_ff @(posedge clock or negedge rstSync) begin
		if (!rstSync) begin
			div_r <= 15'h0000;
			dec_r <= 4'h0;
		end else begin
			div_r <= div_nxt;
			dec_r <= dec_nxt;
		end
	end

	// sequencer
	smc_pkg::smc_state_t st_r, st_nxt;
	logic [15:0] idleCnt_r, idleCnt_nxt, slpCnt_r, slpCnt_nxt;
	logic [17:0] holdCnt_r, holdCnt_nxt;
	logic slp_r, slp_nxt, poll_r, poll_nxt, samp_r, samp_nxt, hold_r, hold_nxt, disc_r, disc_nxt;
	logic cyc;
	always_comb begin
		cyc = isCyclic(mode_r) && !isCoordinator;
		st_nxt = st_r;
		idleCnt_nxt = idleCnt_r;
		slpCnt_nxt = slpCnt_r;
		poll_nxt = 1'b0;
		samp_nxt = 1'b0;
		case (st_r)
			smc_pkg::ST_AWAKE: begin
				if (!cyc || dataActivity)
					idleCnt_nxt = idle_r; // R5 R13
				else if (msTick) begin
					if (idleCnt_r <= 16'h0001) begin
						st_nxt = (assocWanted && assocFailed) ? smc_pkg::ST_UNJOINED : smc_pkg::ST_SLEEP; // R4 R12
						slpCnt_nxt = (assocWanted && assocFailed) ? unj_r : cycle_r; // R8 R12
					end else
						idleCnt_nxt = idleCnt_r - 16'h0001; // R4
				end
			end
			smc_pkg::ST_SLEEP, smc_pkg::ST_UNJOINED: begin
				if (!cyc)
					st_nxt = smc_pkg::ST_AWAKE;
				else if (slpCnt_r == 16'h0000)
					st_nxt = smc_pkg::ST_WAKEUP; // R8
				else if (tenTick)
					slpCnt_nxt = slpCnt_r - 16'h0001; // R8
			end
			smc_pkg::ST_WAKEUP: begin
				poll_nxt = (st_r == smc_pkg::ST_WAKEUP) && !opts_r[smc_pkg::OPT_NO_POLL]; // R2 R14
				samp_nxt = samplingEnabled && !opts_r[smc_pkg::OPT_NO_SAMPLE]; // R3 R14
				idleCnt_nxt = idle_r; // R14
				st_nxt = smc_pkg::ST_AWAKE;
			end
			default: st_nxt = smc_pkg::ST_AWAKE;
		endcase
		slp_nxt = (st_nxt == smc_pkg::ST_SLEEP) || (st_nxt == smc_pkg::ST_UNJOINED);
		// coordinator holding of indirect messages, 10 ms units doubled
		hold_nxt = isCoordinator && (cycle_r != 16'h0000); // R10 R11
		disc_nxt = 1'b0;
		holdCnt_nxt = holdCnt_r;
		if (!hold_nxt || !heldMsgPending)
			holdCnt_nxt = 18'h00000;
		else if (tenTick) begin
			// count 10 ms ticks: 2.5 x period = 5 half-steps of period/2, i.e. 2*cnt >= 5*period
			if ({holdCnt_r, 1'b0} >= 19'({cycle_r, 2'b00} + {3'b000, cycle_r})) begin
				disc_nxt = 1'b1; // R11
				holdCnt_nxt = 18'h00000;
			end else
				holdCnt_nxt = holdCnt_r + 18'h00001;
		end
	end
	always_ff @(posedge clock or negedge rstSync) begin
		if (!rstSync) begin
			st_r <= smc_pkg::ST_AWAKE;
			idleCnt_r <= smc_pkg::IDLE_RST;
			slpCnt_r <= 16'h0000;
			holdCnt_r <= 18'h00000;
			slp_r <= 1'b0;
			poll_r <= 1'b0;
			samp_r <= 1'b0;
			hold_r <= 1'b0;
			disc_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			idleCnt_r <= idleCnt_nxt;
			slpCnt_r <= slpCnt_nxt;
			holdCnt_r <= holdCnt_nxt;
			slp_r <= slp_nxt;
			poll_r <= poll_nxt;
			samp_r <= samp_nxt;
			hold_r <= hold_nxt;
			disc_r <= disc_nxt;
		end
	end
	assign sleeping = slp_r;
	assign pollRequest = poll_r;
	assign sampleRequest = samp_r;
	assign holdIndirect = hold_r;
	assign discardHeld = disc_r;

	a_mode_legal: assert property (@(posedge clock) disable iff (!rstSync) // R1
		mode_r != 8'h03 && mode_r <= smc_pkg::MODE_CYCLIC_PIN) else $error("illegal mode held");
	a_poll_gate: assert property (@(posedge clock) disable iff (!rstSync) // R2
		pollRequest |-> !$past(opts_r[0]) && $past(st_r) == smc_pkg::ST_WAKEUP) else $error("poll not allowed");
	a_sample_gate: assert property (@(posedge clock) disable iff (!rstSync) // R3
		sampleRequest |-> !$past(opts_r[1]) && $past(samplingEnabled)) else $error("sample not allowed");
	a_idle_range: assert property (@(posedge clock) disable iff (!rstSync) // R4
		idle_r != 16'h0000) else $error("idle time zero");
	a_noncyclic_awake: assert property (@(posedge clock) disable iff (!rstSync) // R5
		!isCyclic(mode_r) |=> !slp_r [*2]) else $error("slept outside cyclic mode");
	a_period_range: assert property (@(posedge clock) disable iff (!rstSync) // R8
		cycle_r <= smc_pkg::PERIOD_MAX && unj_r <= smc_pkg::PERIOD_MAX) else $error("period out of range");
	a_direct_zero: assert property (@(posedge clock) disable iff (!rstSync) // R10
		cycle_r == 16'h0000 |=> !holdIndirect) else $error("held with zero period");
	a_activity_restart: assert property (@(posedge clock) disable iff (!rstSync) // R13
		(dataActivity && st_r == smc_pkg::ST_AWAKE) |=> idleCnt_r == $past(idle_r)) else $error("idle not restarted");
	a_wake_then_awake: assert property (@(posedge clock) disable iff (!rstSync) // R14
		st_r == smc_pkg::ST_WAKEUP |=> st_r == smc_pkg::ST_AWAKE && idleCnt_r == $past(idle_r))
		else $error("wake sequence broken");
endmodule : smc_sleep_ctrl

// >>> smc_host_model.sv
// host model writing and reading the sleep configuration
`timescale 1ns/1ns
module smc_host_model (
	// clock
	input wire logic clock,
	// configuration port
	output logic cfgWrite,
	output logic [2:0] cfgSel,
	output logic [15:0] cfgData,
	input wire logic [15:0] cfgReadData,
	input wire logic cfgRefused
);
	initial begin
		cfgWrite = 1'b0;
		cfgSel = 3'h0;
		cfgData = 16'h0000;
	end
	task automatic wr(input logic [2:0] s, input logic [15:0] d, output logic rf);
		@(posedge clock);
		cfgWrite <= 1'b1;
		cfgSel <= s;
		cfgData <= d;
		@(posedge clock);
		cfgWrite <= 1'b0;
		// stale data must not look valid
		cfgData <= ~d;
		#1 rf = cfgRefused;
		@(posedge clock);
		#1 rf = rf | cfgRefused;
	endtask : wr
	task automatic rd(input logic [2:0] s, output logic [15:0] v);
		@(posedge clock);
		cfgSel <= s;
		repeat (2) @(posedge clock);
		#1 v = cfgReadData;
	endtask : rd
endmodule : smc_host_model

// >>> tb_sleep_mode_controller.sv
// self-checking bench for the sleep controller
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_sleep_mode_controller;
	logic clock = 1'b0, rstn = 1'b0, cfgWrite, cfgRefused, dataActivity = 1'b0;
	logic isCoordinator = 1'b0, samplingEnabled = 1'b0, sleeping, pollRequest;
	logic sampleRequest, holdIndirect, discardHeld, rf, p, s;
	logic assocWanted = 1'b0, assocFailed = 1'b0, heldMsgPending = 1'b0;
	logic [2:0] cfgSel;
	logic [15:0] cfgData, cfgReadData, v;
	int n_errors = 0, n_tests = 0, cyc = 0;
	always #25 clock = ~clock;
	smc_host_model host (.clock(clock), .cfgWrite(cfgWrite), .cfgSel(cfgSel), .cfgData(cfgData),
		.cfgReadData(cfgReadData), .cfgRefused(cfgRefused));
	smc_sleep_ctrl dut (.clock(clock), .rstn(rstn), .cfgWrite(cfgWrite), .cfgSel(cfgSel),
		.cfgData(cfgData), .cfgReadData(cfgReadData), .cfgRefused(cfgRefused),
		.dataActivity(dataActivity), .isCoordinator(isCoordinator), .assocWanted(assocWanted),
		.assocFailed(assocFailed), .samplingEnabled(samplingEnabled), .heldMsgPending(heldMsgPending),
		.sleeping(sleeping), .pollRequest(pollRequest), .sampleRequest(sampleRequest),
		.holdIndirect(holdIndirect), .discardHeld(discardHeld));
	task automatic complete_run;
		if (n_errors == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run
	always @(posedge clock) begin
		cyc++;
		if (cyc == 95000) begin
			n_errors++;
			complete_run();
		end
	end
	task automatic t_reset;
		logic [15:0] e [5];
		e = '{16'h0000, 16'h0000, smc_pkg::IDLE_RST, smc_pkg::CYCLE_RST, smc_pkg::UNJOINED_RST};
		for (int i = 0; i < 5; i++) begin
			host.rd(3'(i), v);
			`CHK("reset value", e[i], v)
		end
	endtask : t_reset
	task automatic t_refuse;
		logic [18:0] b [8];
		b = '{{3'h0, 16'h0003}, {3'h0, 16'h0006}, {3'h2, 16'h0000},
			{3'h3, 16'h68b1}, {3'h4, 16'h0000}, {3'h4, 16'h68b1}, {3'h1, 16'h0005}, {3'h5, 16'h0000}};
		for (int i = 0; i < 8; i++) begin
			host.wr(b[i][18:16], b[i][15:0], rf);
			`CHK("refused", 1'b1, rf)
		end
		host.rd(smc_pkg::SEL_MODE, v);
		`CHK("mode kept", 16'h0000, v)
	endtask : t_refuse
	task automatic t_legal;
		logic [18:0] g [8];
		g = '{{3'h0, 16'h0001}, {3'h0, 16'h0002}, {3'h0, 16'h0004}, {3'h0, 16'h0005},
			{3'h0, 16'h0000}, {3'h2, 16'hffff}, {3'h3, 16'h68b0}, {3'h4, 16'h68b0}};
		for (int i = 0; i < 8; i++) begin
			host.wr(g[i][18:16], g[i][15:0], rf);
			`CHK("accepted", 1'b0, rf)
			host.rd(g[i][18:16], v);
			`CHK("read back", g[i][15:0], v)
		end
	endtask : t_legal
	task automatic t_hold;
		logic bad;
		bad = 1'b0;
		@(posedge clock) isCoordinator <= 1'b1;
		heldMsgPending <= 1'b1;
		host.wr(smc_pkg::SEL_CYCLE, 16'h0001, rf);
		@(posedge clock);
		#1 `CHK("hold on", 1'b1, holdIndirect)
		repeat (20) begin
			@(posedge clock);
			#1 bad = bad | discardHeld;
		end
		`CHK("no early discard", 1'b0, bad)
		host.wr(smc_pkg::SEL_CYCLE, 16'h0000, rf);
		@(posedge clock);
		#1 `CHK("hold off", 1'b0, holdIndirect)
		@(posedge clock) isCoordinator <= 1'b0;
		heldMsgPending <= 1'b0;
	endtask : t_hold
	task automatic nap(output logic po, output logic sa);
		int k;
		k = 0;
		while (sleeping !== 1'b1 && k < 21000) begin
			@(posedge clock);
			#1 k++;
		end
		`CHK("asleep", 1'b1, sleeping)
		k = 0;
		while (sleeping !== 1'b0 && k < 20) begin
			@(posedge clock);
			#1 k++;
		end
		`CHK("awake", 1'b0, sleeping)
		// wake pulses follow one cycle after sleeping falls
		@(posedge clock);
		#1 po = pollRequest;
		sa = sampleRequest;
	endtask : nap
	task automatic t_sleep;
		logic bad;
		bad = 1'b0;
		@(posedge clock) dataActivity <= 1'b1;
		samplingEnabled <= 1'b1;
		host.wr(smc_pkg::SEL_IDLE, 16'h0001, rf);
		host.wr(smc_pkg::SEL_MODE, 16'h0004, rf);
		repeat (21000) begin
			@(posedge clock);
			#1 bad = bad | sleeping;
		end
		`CHK("busy no sleep", 1'b0, bad)
		@(posedge clock) dataActivity <= 1'b0;
		nap(p, s);
		`CHK("poll", 1'b1, p)
		`CHK("sample", 1'b1, s)
		host.wr(smc_pkg::SEL_OPTS, 16'h0003, rf);
		nap(p, s);
		`CHK("no poll", 1'b0, p)
		`CHK("no sample", 1'b0, s)
	endtask : t_sleep
	task automatic t_unjoined;
		int k;
		k = 0;
		@(posedge clock) assocWanted <= 1'b1;
		assocFailed <= 1'b1;
		host.wr(smc_pkg::SEL_OPTS, 16'h0000, rf);
		while (sleeping !== 1'b1 && k < 21000) begin
			@(posedge clock);
			#1 k++;
		end
		// cyclic period is zero, so only the unjoined period keeps it asleep
		repeat (10) @(posedge clock);
		#1 `CHK("unjoined asleep", 1'b1, sleeping)
		host.wr(smc_pkg::SEL_MODE, 16'h0000, rf);
		repeat (2) @(posedge clock);
		#1 `CHK("mode exit wake", 1'b0, sleeping)
		`CHK("no poll on exit", 1'b0, pollRequest)
	endtask : t_unjoined
	initial begin
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		repeat (4) @(posedge clock);
		t_reset();
		t_refuse();
		t_legal();
		t_hold();
		t_sleep();
		t_unjoined();
		complete_run();
	end
endmodule : tb_sleep_mode_controller
